// ===== hbc_defines.svh
`ifndef HBC_DEFINES_SVH
`define HBC_DEFINES_SVH
// Command codes
`define HBC_CMD_SCRATCH_RD 8'h28
`define HBC_CMD_SCRATCH_WR 8'hA8
`define HBC_CMD_SOFTRST_WR 8'hA9
`define HBC_CMD_ISOLEN_RD 8'h2A
`define HBC_CMD_ISOLEN_WR 8'hAA
`define HBC_CMD_ASYLEN_RD 8'h2B
`define HBC_CMD_ASYLEN_WR 8'hAB
// Direction bit of a command code, and the latch value before any command
`define HBC_CMD_WRITE_BIT 7
`define HBC_CMD_NONE 8'h00
// Register slots behind the command decoder
`define HBC_SLOT_COUNT 3
`define HBC_SLOT_SCRATCH 0
`define HBC_SLOT_ISO 1
`define HBC_SLOT_ASYNC 2
// Width of one data word on the command bus
`define HBC_WORD_BITS 16
// Soft reset key and reset values
`define HBC_RESET_KEY 16'h00F6
`define HBC_REG_RESET 16'h0000
// Buffer RAM total size in bytes
`define HBC_RAM_BYTES 17'h0_1000
`endif

// ===== hbc_pkg.sv
package hbc_pkg;
  typedef enum logic [2:0] {
    HBC_IDLE = 3'b001,
    HBC_WRITE = 3'b010,
    HBC_READ = 3'b100
  } hbc_state_t;
endpackage

// ===== hbc_word_reg.sv
`timescale 1ns/1ps
`include "hbc_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// One 16-bit register with sync clear and load
module hbc_word_reg #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic load,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] q
);
  // Elaboration check; a zero-width word would vanish silently
  if (WIDTH < 1)
  begin
    $error("hbc_word_reg: WIDTH must be positive");
  end

  // Clear has priority so a soft reset never loses to a same-cycle load
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else if (clear)
      q <= '0;
    else if (load)
      q <= din;
  end
endmodule

// ===== hbc_host_buffer_config_registers.sv
`timescale 1ns/1ps
`include "hbc_defines.svh"
// Functional notes
// - Scratch word: write A8, read 28, reset zero
// - Key F6 at A9 resets registers, not RAM
// - One iso length sizes both iso buffers
// - Iso length is byte count, resets zero
// - Async length: read 2B, write AB, zero
module hbc_host_buffer_config_registers #(
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmdStrobe,
  input wire logic [7:0] cmdCode,
  input wire logic dataWrStrobe,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic dataRdStrobe,
  output logic [DATA_W-1:0] dataOut,
  output logic dataValid,
  output logic softResetPulse,
  output logic [DATA_W-1:0] isoBufferFirstLen,
  output logic [DATA_W-1:0] isoBufferSecondLen,
  output logic [DATA_W-1:0] asyncBufferLen,
  output logic lengthOverflow
);
  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks; the command bus moves whole 16-bit words only
  if (DATA_W != `HBC_WORD_BITS)
  begin
    $error("hbc_host_buffer_config_registers: DATA_W must be 16");
  end
  // A short key constant would let a partial word fire the soft reset
  if ($bits(`HBC_RESET_KEY) != DATA_W)
  begin
    $error("hbc_host_buffer_config_registers: key width must match DATA_W");
  end
  // The budget compare below assumes the RAM size is one bit wider than a word
  if ($bits(`HBC_RAM_BYTES) != DATA_W + 1)
  begin
    $error("hbc_host_buffer_config_registers: RAM size width must be DATA_W plus one");
  end
  // The highest named slot, the async slot, must fall inside the slot array
  if (`HBC_SLOT_ASYNC >= `HBC_SLOT_COUNT)
  begin
    $error("hbc_host_buffer_config_registers: slot index out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command latch: code written once, then data phase reads or writes
  hbc_pkg::hbc_state_t state;
  hbc_pkg::hbc_state_t next_state;
  logic [7:0] curCmd;

  // Bit 7 of a command code marks the write direction
  function automatic logic isWriteCode(input logic [7:0] code);
    isWriteCode = code[`HBC_CMD_WRITE_BIT];
  endfunction

  // Read and write codes of one register share a slot, so a single decoder
  // serves both the load enables and the read mux
  function automatic logic [`HBC_SLOT_COUNT-1:0] slotOf(input logic [7:0] code);
    slotOf = '0;
    if (code == `HBC_CMD_SCRATCH_RD || code == `HBC_CMD_SCRATCH_WR)
      slotOf[`HBC_SLOT_SCRATCH] = 1'b1;
    else if (code == `HBC_CMD_ISOLEN_RD || code == `HBC_CMD_ISOLEN_WR)
      slotOf[`HBC_SLOT_ISO] = 1'b1;
    else if (code == `HBC_CMD_ASYLEN_RD || code == `HBC_CMD_ASYLEN_WR)
      slotOf[`HBC_SLOT_ASYNC] = 1'b1;
  endfunction

  // Where a fresh command leads; a command strobe always wins over data
  hbc_pkg::hbc_state_t cmdTarget;
  assign cmdTarget = isWriteCode(cmdCode) ? hbc_pkg::HBC_WRITE : hbc_pkg::HBC_READ;

  // A write command waits for a data write; a read command for a data read
  always_comb
  begin
    // Hold unless a strobe moves the machine
    next_state = state;
    case (state)
      hbc_pkg::HBC_IDLE:
      begin
        if (cmdStrobe)
          next_state = cmdTarget;
      end
      hbc_pkg::HBC_WRITE:
      begin
        if (cmdStrobe)
          next_state = cmdTarget;
        else if (dataWrStrobe)
          next_state = hbc_pkg::HBC_IDLE; // One word per command
      end
      hbc_pkg::HBC_READ:
      begin
        if (cmdStrobe)
          next_state = cmdTarget;
        else if (dataRdStrobe)
          next_state = hbc_pkg::HBC_IDLE;
      end
      default:
      begin
        next_state = hbc_pkg::HBC_IDLE; // Recover from an illegal code
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and command registers
  // Phase of the host transaction
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= hbc_pkg::HBC_IDLE;
    else
      state <= next_state;
  end

  // Code latched on every command strobe, kept for the data phase
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      curCmd <= `HBC_CMD_NONE;
    else if (cmdStrobe)
      curCmd <= cmdCode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  // Data strobes count only in the matching phase; a command strobe wins
  wire writeNow = (state == hbc_pkg::HBC_WRITE) && dataWrStrobe && !cmdStrobe;
  wire readNow = (state == hbc_pkg::HBC_READ) && dataRdStrobe && !cmdStrobe;
  // Decoded slot of the pending command, shared by load and read paths
  wire [`HBC_SLOT_COUNT-1:0] curSlot = slotOf(curCmd);
  wire [`HBC_SLOT_COUNT-1:0] slotLoad = curSlot & {`HBC_SLOT_COUNT{writeNow}};
  // Only the exact key fires; any other value is dropped silently
  // Full-word compare, so a stray upper byte can never reset the controller
  wire keyHit = writeNow && (curCmd == `HBC_CMD_SOFTRST_WR)
    && (dataIn == `HBC_RESET_KEY);

  // Soft reset pulse, one cycle, drives the rest of the controller too
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      softResetPulse <= 1'b0;
    else
      softResetPulse <= keyHit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage; the buffer RAM lives elsewhere
  // and is never touched by the key
  logic [DATA_W-1:0] scratchStore;
  logic [DATA_W-1:0] isoBufferLength;
  logic [DATA_W-1:0] asyncBufferLength;
  wire [DATA_W-1:0] slotQ [`HBC_SLOT_COUNT];

  // One word register per slot; the key clears them all in one cycle
  // Slot order follows the slot defines; add a slot there first
  for (genvar gi = 0; gi < `HBC_SLOT_COUNT; gi++)
  begin : gen_slot
    hbc_word_reg #(
      .WIDTH(DATA_W)
    ) hbc_word_reg_inst (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clear(keyHit),
      .load(slotLoad[gi]),
      .din(dataIn),
      .q(slotQ[gi])
    );
  end

  // Named views of the slots
  assign scratchStore = slotQ[`HBC_SLOT_SCRATCH];
  assign isoBufferLength = slotQ[`HBC_SLOT_ISO];
  assign asyncBufferLength = slotQ[`HBC_SLOT_ASYNC];

  // Both iso buffers share the one byte count
  assign isoBufferFirstLen = isoBufferLength;
  assign isoBufferSecondLen = isoBufferLength;
  assign asyncBufferLen = asyncBufferLength;

  // Lengths widened before the sum so a large pair can never wrap
  // past the limit and hide an over-subscribed RAM
  wire [DATA_W:0] isoTwice = {isoBufferLength, 1'b0};
  wire [DATA_W+1:0] asyncWide = {2'b00, asyncBufferLength};
  wire [DATA_W+1:0] totalBytes = {1'b0, isoTwice} + asyncWide;
  wire [DATA_W+1:0] ramLimit = {1'b0, `HBC_RAM_BYTES};
  // Hardware does not clamp; flag only, the driver owns the budget
  assign lengthOverflow = totalBytes > ramLimit;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; the reset key register has no read code and reads as zero
  // Unknown read codes answer zero but still pulse valid
  wire [DATA_W-1:0] readMux =
    curSlot[`HBC_SLOT_SCRATCH] ? scratchStore :
    curSlot[`HBC_SLOT_ISO] ? isoBufferLength :
    curSlot[`HBC_SLOT_ASYNC] ? asyncBufferLength :
    `HBC_REG_RESET;

  // Read answer: valid pulses one cycle, data holds until the next read
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataOut <= `HBC_REG_RESET; // Nothing readable yet
      dataValid <= 1'b0;
    end
    else
    begin
      dataValid <= readNow;
      if (readNow)
      begin
        dataOut <= readMux;
      end
    end
  end
endmodule

// ===== hbc_host_buffer_config_registers_assertions.sv
`timescale 1ns/1ps
module hbc_host_buffer_config_registers_assertions (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmdStrobe,
  input wire logic [7:0] cmdCode,
  input wire logic dataWrStrobe,
  input wire logic [15:0] dataIn,
  input wire logic dataRdStrobe,
  input wire logic [15:0] dataOut,
  input wire logic dataValid,
  input wire logic softResetPulse,
  input wire logic [15:0] isoBufferFirstLen,
  input wire logic [15:0] isoBufferSecondLen,
  input wire logic [15:0] asyncBufferLen,
  input wire logic lengthOverflow
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // Full key word seen on the previous edge
  sequence keyHit;
    $past(dataWrStrobe) && $past(dataIn) == 16'h00F6;
  endsequence
  // Port relations
  chk_read_answer: assert property (dataValid |-> $past(dataRdStrobe))
    else $error("read answer without read strobe");
  chk_soft_clear: assert property (softResetPulse |-> !(isoBufferFirstLen | asyncBufferLen))
    else $error("lengths not cleared by soft reset");
  chk_key_only: assert property (softResetPulse |-> keyHit)
    else $error("soft reset without full key");
  chk_iso_twin: assert property (isoBufferFirstLen == isoBufferSecondLen)
    else $error("iso buffers differ in size");
  chk_len_bytes: assert property (lengthOverflow ==
    ({2'b00, asyncBufferLen} + {1'b0, isoBufferFirstLen, 1'b0} > 18'h0_1000))
    else $error("overflow flag wrong for byte sizes");
  chk_async_hold: assert property (!$past(dataWrStrobe) |-> $stable(asyncBufferLen))
    else $error("async length moved without write");
  // Command cycle followed by its data word on the next edge
  sequence isoWrite;
    (cmdStrobe && cmdCode == 8'hAA) ##1 (dataWrStrobe && !cmdStrobe);
  endsequence
  sequence asyncWrite;
    (cmdStrobe && cmdCode == 8'hAB) ##1 (dataWrStrobe && !cmdStrobe);
  endsequence
  sequence keyWrite;
    (cmdStrobe && cmdCode == 8'hA9) ##1 (dataWrStrobe && !cmdStrobe && dataIn == 16'h00F6);
  endsequence
  sequence isoRead;
    (cmdStrobe && cmdCode == 8'h2A) ##1 (dataRdStrobe && !cmdStrobe);
  endsequence
  // Transfers and their effect one edge later
  chk_iso_load: assert property (isoWrite |=>
    (isoBufferFirstLen == $past(dataIn)) && (isoBufferSecondLen == $past(dataIn)))
    else $error("iso length write did not land in both buffers");
  chk_async_load: assert property (asyncWrite |=> asyncBufferLen == $past(dataIn))
    else $error("async length write did not land");
  chk_key_fires: assert property (keyWrite |=> softResetPulse && asyncBufferLen == 16'h0000)
    else $error("full key did not reset the registers");
  chk_iso_read: assert property (isoRead |=> dataValid && dataOut == isoBufferFirstLen)
    else $error("iso length read answer wrong");
endmodule
bind hbc_host_buffer_config_registers hbc_host_buffer_config_registers_assertions hbc_chk_inst (
  .ref_clk, .rst_b, .cmdStrobe, .cmdCode, .dataWrStrobe, .dataIn, .dataRdStrobe, .dataOut,
  .dataValid, .softResetPulse, .isoBufferFirstLen, .isoBufferSecondLen, .asyncBufferLen,
  .lengthOverflow);

// ===== hbc_host_model.sv
`timescale 1ns/1ps
module hbc_host_model (
  input wire logic ref_clk,
  output logic cmdStrobe,
  output logic [7:0] cmdCode,
  output logic dataWrStrobe,
  output logic [15:0] dataIn,
  output logic dataRdStrobe,
  input wire logic [15:0] dataOut,
  input wire logic dataValid
);
  // Quiet bus at time zero
  initial
  begin
    {cmdStrobe, dataWrStrobe, dataRdStrobe, cmdCode, dataIn} = '0;
  end
  // Command cycle; code inverted after so no stale value lingers
  task send(input logic [7:0] c);
    @(posedge ref_clk) #1;
    cmdStrobe = 1;
    cmdCode = c;
    @(posedge ref_clk) #1;
    cmdStrobe = 0;
    cmdCode = ~c;
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d);
    send(c);
    dataWrStrobe = 1;
    dataIn = d;
    @(posedge ref_clk) #1;
    dataWrStrobe = 0;
    dataIn = ~d;
  endtask
  // Answer is registered, so taken one edge after the strobe
  task rd(input logic [7:0] c, output logic [16:0] q);
    send(c);
    dataRdStrobe = 1;
    @(posedge ref_clk) #1;
    dataRdStrobe = 0;
    q = {dataValid, dataOut};
  endtask
endmodule

// ===== hbc_host_buffer_config_registers_bench.sv
`timescale 1ns/1ps
module hbc_host_buffer_config_registers_bench;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic cmdStrobe, dataWrStrobe, dataRdStrobe, dataValid, softResetPulse, lengthOverflow;
  logic [7:0] cmdCode;
  logic [15:0] dataIn, dataOut, iso0, iso1, asy;
  logic [16:0] got;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  hbc_host_buffer_config_registers hbc_host_buffer_config_registers_inst (.ref_clk, .rst_b,
    .cmdStrobe, .cmdCode, .dataWrStrobe, .dataIn, .dataRdStrobe, .dataOut, .dataValid,
    .softResetPulse, .isoBufferFirstLen(iso0), .isoBufferSecondLen(iso1),
    .asyncBufferLen(asy), .lengthOverflow);
  hbc_host_model hbc_host_model_inst (.ref_clk, .cmdStrobe, .cmdCode, .dataWrStrobe,
    .dataIn, .dataRdStrobe, .dataOut, .dataValid);
  task cmp(input logic [16:0] g, input logic [16:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d);
    hbc_host_model_inst.wr(c, d);
  endtask
  // Valid flag travels as the top bit of the compared word
  task rd(input logic [7:0] c, input logic [16:0] e);
    hbc_host_model_inst.rd(c, got);
    cmp(got, e);
  endtask
  // Hang guard, far above the roughly sixty cycles needed
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end
  // Register sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1 rst_b = 1;
    rd(8'h28, 17'h1_0000);
    rd(8'h2A, 17'h1_0000);
    rd(8'h2B, 17'h1_0000);
    wr(8'hA8, 16'hA5C3);
    wr(8'hAA, 16'h0400);
    wr(8'hAB, 16'h0800);
    rd(8'h28, 17'h1_A5C3);
    rd(8'h2A, 17'h1_0400);
    rd(8'h2B, 17'h1_0800);
    cmp({lengthOverflow, iso1}, 17'h0_0400);
    wr(8'hAA, 16'h0401);
    cmp({lengthOverflow, asy}, 17'h1_0800);
    wr(8'hA9, 16'h01F6);
    cmp({softResetPulse, iso0}, 17'h0_0401);
    rd(8'h29, 17'h1_0000);
    wr(8'hA9, 16'h00F6);
    cmp({softResetPulse, iso0}, 17'h1_0000);
    rd(8'h28, 17'h1_0000);
    rd(8'h2B, 17'h1_0000);
    tally_and_finish;
  end
endmodule
